// File: rtl/wdg_pkg.sv
// Constants shared by the watchdog and init controller and its SPI frontend.
// Assumes a 10 MHz system clock and a 16-bit SPI frame: R/W, 7-bit addr, 8-bit data.
`default_nettype none
package wdg_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [6:0] ADDR_MAIN_CONTROL = 7'h00;
    localparam logic [6:0] ADDR_WDG_PERIOD = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h05;
    localparam logic [6:0] ADDR_LH_FIRST = 7'h1E;
    localparam logic [6:0] ADDR_LH_LAST = 7'h2D;
    localparam logic [6:0] ADDR_EXIT_KEY = 7'h2E;
    localparam logic [7:0] EXIT_KEY_WDG = 8'hD4;
    localparam logic [7:0] EXIT_KEY_ALT = 8'hC3;
    // Field positions.
    localparam int CTL_CH0_EN = 0;
    localparam int CTL_CH1_EN = 2;
    localparam int CTL_WDG_EN = 4;
    localparam int CTL_LH_SW = 5;
    localparam int CTL_FAULT_ACK = 7;
    localparam int ST_POWER_CYCLE = 2;
    localparam int ST_WDG_EXPIRED = 3;
    localparam int ST_STANDALONE = 7;
    // Reset values: watchdog on, channels off.
    localparam logic [7:0] CTL_RESET = 8'h90;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int WDG_DEFAULT_MS = 1550;
    localparam int WDG_DEFAULT_CYCLES = (WDG_DEFAULT_MS / 1000) * CLK_HZ
        + ((WDG_DEFAULT_MS % 1000) * (CLK_HZ / 1000));
    localparam int WDG_STEP_MS = 50;
    localparam int WDG_STEP_CYCLES = WDG_STEP_MS * (CLK_HZ / 1000);
    localparam int SPI_FRAME_BITS = 16;
endpackage
`default_nettype wire

// File: rtl/spi_frontend.sv
// SPI target: mode 0, MSB first, 16-bit frames, read data returned in the frame's low byte.
// Assumes sclk, cs_b and mosi come from another domain; each passes three flip-flops.
`default_nettype none
module spi_frontend
    import wdg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic [7:0] rd_data,
    output logic miso,
    output logic acc_valid,
    output logic acc_write,
    output logic [6:0] acc_addr,
    output logic [7:0] acc_wdata,
    output logic rd_strobe
);
    typedef struct packed {
        logic [2:0] sck_s;
        logic [2:0] cs_s;
        logic [2:0] mo_s;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [7:0] tx;
        logic miso;
        logic valid;
        logic write;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic rd;
    } spi_state_t;
    spi_state_t s_q, s_d;
    logic sck_rise, sck_fall, sel;
    // ************************************************************
    // Frame assembly
    // ************************************************************
    // Edges count only where the second and third stages differ, never from the first.
    assign sck_rise = s_q.sck_s[1] & ~s_q.sck_s[2];
    assign sck_fall = ~s_q.sck_s[1] & s_q.sck_s[2];
    assign sel = ~s_q.cs_s[1] & ~s_q.cs_s[2];
    always_comb begin
        s_d = s_q;
        s_d.sck_s = {s_q.sck_s[1:0], sclk};
        s_d.cs_s = {s_q.cs_s[1:0], cs_b};
        s_d.mo_s = {s_q.mo_s[1:0], mosi};
        s_d.valid = 1'b0;
        s_d.rd = 1'b0;
        if (!sel) begin
            s_d.cnt = 5'h00;
            s_d.miso = 1'b0;
        end else if (sck_rise) begin
            s_d.sh = {s_q.sh[14:0], s_q.mo_s[2]};
            s_d.cnt = s_q.cnt + 5'h01;
            // After the address byte, publish the address; read data follows a cycle later.
            if (s_q.cnt == 5'h07) begin
                s_d.addr = {s_q.sh[5:0], s_q.mo_s[2]};
                s_d.rd = ~s_q.sh[6];
            end
            if (s_q.cnt == 5'(SPI_FRAME_BITS - 1)) begin
                s_d.valid = 1'b1;
                s_d.write = s_q.sh[14];
                s_d.wdata = {s_q.sh[6:0], s_q.mo_s[2]};
            end
        end else if (sck_fall && s_q.cnt >= 5'h08) begin
            s_d.miso = s_q.tx[7];
            s_d.tx = {s_q.tx[6:0], 1'b0};
        end
        // Read data is taken once the new address stands, else the old register would leak out.
        if (s_q.rd) begin
            s_d.tx = rd_data;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{sck_s: 3'h0, cs_s: 3'h7, mo_s: 3'h0, cnt: 5'h00, sh: 16'h0000,
                     tx: 8'h00, miso: 1'b0, valid: 1'b0, write: 1'b0, addr: 7'h00,
                     wdata: 8'h00, rd: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    assign miso = s_q.miso;
    assign acc_valid = s_q.valid;
    assign acc_write = s_q.write;
    assign acc_addr = s_q.addr;
    assign acc_wdata = s_q.wdata;
    assign rd_strobe = s_q.rd;
endmodule
`default_nettype wire

// File: rtl/init_watchdog_standalone_ctrl.sv
// Power-up watchdog, standalone entry and exit, limp-home arming for a two-channel driver.
// Assumes an SPI controller on the pins and a power-on reset on rst_b.
`default_nettype none
module init_watchdog_standalone_ctrl
    import wdg_pkg::*;
#(
    parameter int WDG_DEFAULT = WDG_DEFAULT_CYCLES,
    parameter int WDG_STEP = WDG_STEP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic fault_event,
    output logic miso,
    output logic [1:0] channel_enable,
    output logic standalone,
    output logic limp_home_active,
    output logic fault_indicator,
    output logic [7:0] limp_home_cfg_out
);
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_ALONE = 3'b010,
        ST_LIMP = 3'b100
    } mode_t;
    typedef struct packed {
        mode_t mode;
        logic [7:0] ctl;
        logic [7:0] period;
        logic [31:0] wdg_cnt;
        logic pc_flag;
        logic expired;
        logic fault;
        logic lh_sw_prev;
        logic lh_test;
        logic [3:0] lh_idx;
        logic [1:0] ch_out;
    } ctrl_state_t;
    ctrl_state_t s_q, s_d;
    logic [7:0] lh_mem [0:15];
    logic acc_valid, acc_write, rd_strobe;
    logic [6:0] acc_addr;
    logic [7:0] acc_wdata, rd_data, status;
    logic [31:0] limit;
    logic [1:0] ch_q;
    logic alone_q, limp_q, flt_q;
    logic [7:0] lh_cfg_q;

    function automatic logic in_lh(input logic [6:0] a);
        in_lh = (a >= ADDR_LH_FIRST) && (a <= ADDR_LH_LAST);
    endfunction

    spi_frontend u_spi (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sclk(sclk),
        .cs_b(cs_b),
        .mosi(mosi),
        .rd_data(rd_data),
        .miso(miso),
        .acc_valid(acc_valid),
        .acc_write(acc_write),
        .acc_addr(acc_addr),
        .acc_wdata(acc_wdata),
        .rd_strobe(rd_strobe)
    );

    // ************************************************************
    // Read path
    // ************************************************************
    // Status shows standalone mode, expiry, the power-cycle flag and the fault latch.
    always_comb begin
        status = 8'h00;
        status[ST_STANDALONE] = (s_q.mode == ST_ALONE);
        status[ST_WDG_EXPIRED] = s_q.expired;
        status[ST_POWER_CYCLE] = s_q.pc_flag;
        status[0] = s_q.fault;
        unique case (1'b1)
            acc_addr == ADDR_MAIN_CONTROL: rd_data = s_q.ctl;
            acc_addr == ADDR_WDG_PERIOD: rd_data = s_q.period;
            acc_addr == ADDR_STATUS: rd_data = status;
            in_lh(acc_addr): rd_data = lh_mem[4'(acc_addr - ADDR_LH_FIRST)];
            default: rd_data = 8'h00;
        endcase
    end

    // Zero period keeps the default; otherwise steps of fixed length.
    assign limit = (s_q.period == 8'h00) ? 32'(WDG_DEFAULT)
        : 32'(s_q.period) * 32'(WDG_STEP);

    // ************************************************************
    // Control and watchdog
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.lh_sw_prev = s_q.ctl[CTL_LH_SW];
        if (fault_event) begin
            s_d.fault = 1'b1;
        end
        // Watchdog counts while enabled; any valid access restarts it.
        if (acc_valid) begin
            s_d.wdg_cnt = 32'h0;
        end else if (s_q.ctl[CTL_WDG_EN] && s_q.wdg_cnt < limit) begin
            s_d.wdg_cnt = s_q.wdg_cnt + 32'h1;
        end
        if (rd_strobe && acc_addr == ADDR_STATUS) begin
            s_d.pc_flag = 1'b0;
        end
        if (acc_valid && acc_write) begin
            unique case (1'b1)
                acc_addr == ADDR_MAIN_CONTROL: begin
                    s_d.ctl = acc_wdata;
                    // A zero in bit seven acknowledges the fault; a new fault still wins.
                    if (!acc_wdata[CTL_FAULT_ACK] && !fault_event) begin
                        s_d.fault = 1'b0;
                    end
                end
                acc_addr == ADDR_WDG_PERIOD: s_d.period = acc_wdata;
                acc_addr == ADDR_EXIT_KEY: begin
                    if ((acc_wdata == EXIT_KEY_WDG || acc_wdata == EXIT_KEY_ALT)
                        && s_q.mode == ST_ALONE) begin
                        s_d.mode = ST_NORMAL;
                    end
                end
                default: ;
            endcase
        end
        // Expiry: standalone until the status register is first read, limp-home afterwards.
        if (s_q.ctl[CTL_WDG_EN] && s_q.wdg_cnt >= limit && !acc_valid) begin
            s_d.expired = 1'b1;
            if (s_q.mode == ST_NORMAL) begin
                s_d.mode = s_q.pc_flag ? ST_ALONE : ST_LIMP;
            end
            s_d.wdg_cnt = 32'h0;
        end
        if (s_q.mode == ST_LIMP && acc_valid) begin
            s_d.mode = ST_NORMAL;
        end
        // Limp-home test follows a toggle of the switch bit, only with watchdog on.
        if (s_q.ctl[CTL_LH_SW] != s_q.lh_sw_prev) begin
            s_d.lh_test = s_q.ctl[CTL_WDG_EN] ? ~s_q.lh_test : 1'b0;
        end
        if (!s_q.ctl[CTL_WDG_EN]) begin
            s_d.lh_test = 1'b0;
        end
        s_d.lh_idx = s_q.lh_idx + 4'h1;
        s_d.ch_out = {s_q.ctl[CTL_CH1_EN], s_q.ctl[CTL_CH0_EN]};
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{mode: ST_NORMAL, ctl: CTL_RESET, period: PERIOD_RESET, wdg_cnt: 32'h0,
                     pc_flag: 1'b1, expired: 1'b0, fault: 1'b0, lh_sw_prev: 1'b0,
                     lh_test: 1'b0, lh_idx: 4'h0, ch_out: 2'b00};
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Limp-home storage
    // ************************************************************
    // Written over SPI; no reset so it maps to plain storage.
    always_ff @(posedge clk_sys) begin
        if (acc_valid && acc_write && in_lh(acc_addr)) begin
            lh_mem[4'(acc_addr - ADDR_LH_FIRST)] <= acc_wdata;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    // Standalone, limp-home or test drives both channels; otherwise the enables apply.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ch_q <= 2'b00;
            alone_q <= 1'b0;
            limp_q <= 1'b0;
            flt_q <= 1'b0;
            lh_cfg_q <= 8'h00;
        end else begin
            limp_q <= (s_q.mode == ST_LIMP) || s_q.lh_test;
            alone_q <= (s_q.mode == ST_ALONE);
            ch_q <= (s_q.mode != ST_NORMAL || s_q.lh_test) ? 2'b11 : s_q.ch_out;
            flt_q <= s_q.fault;
            lh_cfg_q <= lh_mem[s_q.lh_idx];
        end
    end
    assign channel_enable = ch_q;
    assign standalone = alone_q;
    assign limp_home_active = limp_q;
    assign fault_indicator = flt_q;
    assign limp_home_cfg_out = lh_cfg_q;
endmodule
`default_nettype wire

// File: sim/init_watchdog_standalone_ctrl_sva.sv
// Checker for the watchdog and standalone controller, bound to its top module.
// Assumes the host keeps cs_b high between SPI frames.
`default_nettype none
module init_watchdog_standalone_ctrl_sva #(
    parameter int WDG_DEFAULT = 2000,
    parameter int WDG_STEP = 100
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic fault_event,
    input wire logic [1:0] channel_enable,
    input wire logic standalone,
    input wire logic limp_home_active,
    input wire logic fault_indicator
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] idle_q;
    logic [7:0] idle_d;
    // ********
    // Helpers
    // ********
    // Cycles since the select line went high; it saturates so a long idle never looks short.
    always_comb idle_d = cs_b ? idle_q + {7'h00, idle_q != 8'hFF} : 8'h00;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) idle_q <= 8'h00;
        else idle_q <= idle_d;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // Mode changes must follow a frame or a long quiet spell, never arrive at random.
    a_reset_state: assert property ($rose(rst_b) |-> channel_enable == 2'b00 && !standalone)
        else $error("outputs not clear after reset");
    a_standalone_cause: assert property ($rose(standalone) |-> idle_q == 8'hFF)
        else $error("standalone entered while host active");
    a_standalone_chans: assert property (standalone && $past(standalone) |->
        channel_enable == 2'b11) else $error("channels not forced in standalone");
    a_fault_set: assert property (fault_event |-> ##[1:2] fault_indicator)
        else $error("fault not latched");
    a_fault_clear: assert property ($fell(fault_indicator) |-> idle_q < 8'd12)
        else $error("fault cleared without a write");
    a_idle_chans: assert property (idle_q > 8'd20 && !$past(standalone) &&
        !$past(limp_home_active) && !standalone && !limp_home_active |->
        $stable(channel_enable)) else $error("channels changed while idle");
    a_exit_cause: assert property ($fell(standalone) |-> idle_q < 8'd12)
        else $error("standalone left without a write");
    a_limp_chans: assert property (limp_home_active && $past(limp_home_active) |->
        channel_enable == 2'b11) else $error("channels not forced in limp home");
    a_limp_cause: assert property ($rose(limp_home_active) |->
        idle_q < 8'd12 || idle_q == 8'hFF) else $error("limp home without cause");
endmodule
bind init_watchdog_standalone_ctrl init_watchdog_standalone_ctrl_sva #(
    .WDG_DEFAULT(WDG_DEFAULT), .WDG_STEP(WDG_STEP)) chk_u (.clk_sys(clk_sys),
    .rst_b(rst_b), .cs_b(cs_b), .fault_event(fault_event), .channel_enable(channel_enable),
    .standalone(standalone), .limp_home_active(limp_home_active),
    .fault_indicator(fault_indicator));
`default_nettype wire

// File: sim/spi_host.sv
// Host controller model: mode 0, MSB first, 16-bit frames.
// Assumes the design samples sclk with clk_sys; half is the sclk half period in cycles.
`default_nettype none
module spi_host (
    input wire logic clk_sys,
    input wire logic miso,
    output logic sclk,
    output logic cs_b,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 1ns;
    int half = 4;
    // ******
    // Frames
    // ******
    // The clock stands low outside frames; the released data line shows the inverse of its last bit.
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
    end
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
        @(posedge clk_sys);
        cs_b <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi <= f[i];
            repeat (half) @(posedge clk_sys);
            sclk <= 1'b1;
            if (i < 8) rd[i] = miso;
            repeat (half) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        mosi <= ~f[0];
        repeat (half) @(posedge clk_sys);
        cs_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// File: sim/init_watchdog_standalone_ctrl_test.sv
// Bench for the watchdog and standalone controller, driven through its SPI pins.
// Assumes the package, design, host model and checker are compiled first.
`default_nettype none
`define chk(nm, ex, sn) \
    begin \
        tests_run++; \
        if ((sn) !== (ex)) begin \
            fail_count++; \
            $display("wrong value %s expected %0h seen %0h", nm, ex, sn); \
        end \
    end
module init_watchdog_standalone_ctrl_test
    import wdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_b, fault_event, sclk, cs_b, mosi, miso, standalone;
    logic limp_home_active, fault_indicator;
    logic [1:0] channel_enable;
    logic [7:0] rd;
    logic [7:0] lh_cfg;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    // Short counts keep the run brief: 2000 cycles default, 100 cycles a period step.
    init_watchdog_standalone_ctrl #(.WDG_DEFAULT(2000), .WDG_STEP(100)) dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .mosi(mosi),
        .fault_event(fault_event), .miso(miso), .channel_enable(channel_enable),
        .standalone(standalone), .limp_home_active(limp_home_active),
        .fault_indicator(fault_indicator), .limp_home_cfg_out(lh_cfg));
    spi_host host_u (.clk_sys(clk_sys), .miso(miso), .sclk(sclk), .cs_b(cs_b), .mosi(mosi));
    // *****
    // Tasks
    // *****
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // A hang costs a mismatch and goes straight to the verdict.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic reboot();
        rst_b <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b1, a, d}, rd);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input logic [7:0] m);
        host_u.xfer({1'b0, a, 8'h00}, rd);
        `chk("read data", e & m, rd & m)
    endtask
    task automatic fault_hit();
        @(posedge clk_sys) fault_event <= 1'b1;
        @(posedge clk_sys) fault_event <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `chk("fault", 1'b1, fault_indicator)
    endtask
    // Main sequence: power-up, watchdog service and expiry, limp test, standalone.
    initial begin
        rst_b = 1'b0;
        fault_event = 1'b0;
        reboot();
        @(posedge clk_sys);
        `chk("ch_en", 2'b00, channel_enable)
        rdchk(ADDR_MAIN_CONTROL, CTL_RESET, 8'hFF);
        rdchk(ADDR_STATUS, 8'h04, 8'hFF);
        rdchk(ADDR_STATUS, 8'h00, 8'hFF);
        fault_hit();
        wr(ADDR_MAIN_CONTROL, 8'h10);
        `chk("fault", 1'b0, fault_indicator)
        wr(ADDR_WDG_PERIOD, 8'h03);
        repeat (240) @(posedge clk_sys);
        `chk("limp", 1'b0, limp_home_active)
        repeat (120) @(posedge clk_sys);
        `chk("limp", 1'b1, limp_home_active)
        `chk("ch_en", 2'b11, channel_enable)
        rdchk(ADDR_STATUS, 8'h08, 8'h8D);
        `chk("limp", 1'b0, limp_home_active)
        wr(ADDR_MAIN_CONTROL, 8'h30);
        `chk("limp", 1'b1, limp_home_active)
        wr(ADDR_MAIN_CONTROL, 8'h10);
        `chk("limp", 1'b0, limp_home_active)
        fault_hit();
        wr(ADDR_MAIN_CONTROL, 8'h00);
        `chk("fault", 1'b0, fault_indicator)
        wr(ADDR_MAIN_CONTROL, 8'h20);
        `chk("limp", 1'b0, limp_home_active)
        for (int i = 0; i < 16; i++)
            wr(ADDR_LH_FIRST + 7'(i), 8'hA0 ^ 8'(i));
        for (int i = 0; i < 16; i++)
            rdchk(ADDR_LH_FIRST + 7'(i), 8'hA0 ^ 8'(i), 8'hFF);
        `chk("limp cfg", 8'hA0, lh_cfg & 8'hF0)
        wr(7'h7F, 8'h5A);
        rdchk(7'h7F, 8'h00, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_MAIN_CONTROL, {5'h00, i[1], 1'b0, i[0]});
            `chk("ch_en", i[1:0], channel_enable)
        end
        repeat (2500) @(posedge clk_sys);
        `chk("standalone", 1'b0, standalone)
        `chk("limp", 1'b0, limp_home_active)
        for (int k = 0; k < 2; k++) begin
            host_u.half = 4 + 4 * k;
            reboot();
            repeat (1900) @(posedge clk_sys);
            `chk("standalone", 1'b0, standalone)
            repeat (200) @(posedge clk_sys);
            `chk("standalone", 1'b1, standalone)
            rdchk(ADDR_STATUS, 8'h84, 8'h84);
            wr(ADDR_EXIT_KEY, 8'h55);
            `chk("standalone", 1'b1, standalone)
            wr(ADDR_EXIT_KEY, (k == 0) ? EXIT_KEY_WDG : EXIT_KEY_ALT);
            `chk("standalone", 1'b0, standalone)
        end
        close_out();
    end
endmodule
`default_nettype wire
